// [hw/mpbp_port.sv]
// memory and peripheral bus port: wishbone register slave driving the external bus
// assumes all pins synchronous to sys_clk; wire levels resolved outside from enables
//
// Contract
// (R1) names ending _n are asserted low
// (R2) read_not_write high reads, low writes
// (R3) lane strobe 0 bits 7:0, 1 bits 15:8
// (R4) alternate master asserts request to own bus
// (R5) grant asserted once bus is given up
// (R6) six active low device selects
// (R7) drive 22-bit address; upper bits elsewhere
// (R8) data pins bidirectional; boot vector at cold reset
// (R9) output enable low while device drives data
// (R10) active low external buffer enable
// (R11) transceiver direction control output
// (R12) cold reset initialises and loads boot configuration
// (R13) warm reset pin bidirectional, driven during reset
// (R14) bus clock derived from master clock
// (R15) boot bit 7 selects boot width
// (R16) warm reset driven at least 4096 cycles
// (R17) boot bit 12 disables watchdog
// (R18) reserved boot bits driven low outside
// (R19) released to high impedance while granted
// (R20) select, address, direction change on bus clock rise
`default_nettype none

module mpbp_port
  import mpbp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic bus_clock_out,
  input wire logic power_on_reset_in_n,
  input wire logic soft_reset_io_n_i,
  output logic soft_reset_io_n_o,
  output logic soft_reset_io_n_oe,
  output logic transceiver_dir_n,
  output logic buffer_output_en_n,
  input wire logic bus_ownership_request_n,
  output logic bus_handover_n,
  output logic bus_drive_en,
  output logic [1:0] lane_write_strobe_n,
  output logic [5:0] device_select_n,
  output logic [21:0] ext_addr,
  input wire logic [15:0] ext_data_i,
  output logic [15:0] ext_data_o,
  output logic ext_data_oe,
  output logic read_drive_en_n,
  output logic read_not_write,
  output logic boot_width_16,
  output logic watchdog_en
);

  mpbp_main_t s_q;
  mpbp_main_t s_d;
  logic req;
  logic tick;
  logic wr;
  logic busy;
  logic granted;
  logic warm_active;
  logic cold;
  logic [15:0] boot_vec;
  logic [31:0] cur;
  logic [31:0] m;
  logic [31:0] wv;
  logic [5:0] cs_dec;

  ////////////////////////////////////////////////////////////////////////////
  mpbp_reset_ctl u_rst (
    .sys_clk(sys_clk),
    .rst(rst),
    .power_on_reset_in_n(power_on_reset_in_n),
    .soft_reset_in(soft_reset_io_n_i),
    .soft_reset_out(soft_reset_io_n_o),
    .soft_reset_oe(soft_reset_io_n_oe),
    .sw_warm_req(s_q.warm_req),
    .ext_data_in(ext_data_i),
    .boot_vec(boot_vec),
    .warm_active(warm_active)
  );

  mpbp_arbiter u_arb (
    .sys_clk(sys_clk),
    .rst(rst),
    .bus_ownership_request_n(bus_ownership_request_n),
    .bus_idle(s_q.st == ST_IDLE),
    .tick(tick),
    .granted(granted)
  );

  ////////////////////////////////////////////////////////////////////////////
  // request decode and read mux
  assign cold = ~power_on_reset_in_n;
  assign req = wb_cyc_i & wb_stb_i;
  assign wr = req & ~s_q.ack & wb_we_i;
  assign busy = (s_q.st != ST_IDLE) | s_q.pend;
  // rising bus clock edge follows every sys_clk edge where phase is low
  assign tick = ~s_q.ph;

  // read mux on the raw address; unmapped offsets read zero
  always_comb
  begin
    cur = 32'h0000_0000;
    unique case (wb_adr_i)
      REG_CTRL:
      begin
        cur[CTRL_WAIT_LSB +: 4] = s_q.waits;
        cur[CTRL_LANE_LSB +: 2] = s_q.lanes;
      end
      REG_ADDR:
      begin
        cur[21:0] = s_q.addr;
        cur[ADDR_CS_LSB +: 3] = s_q.csel;
      end
      REG_WDATA: cur[15:0] = s_q.wdata;
      REG_RDATA: cur[15:0] = s_q.rdata;
      REG_STATUS:
      begin
        cur[STAT_BUSY_BIT] = busy;
        cur[STAT_DONE_BIT] = s_q.done;
        cur[STAT_GRANT_BIT] = granted;
        cur[STAT_WARM_BIT] = warm_active;
        cur[STAT_WIDTH_BIT] = boot_vec[BOOT_WIDTH_BIT];
        cur[STAT_WDT_BIT] = ~boot_vec[BOOT_WDT_BIT];
        cur[STAT_BOOT_LSB +: 16] = boot_vec;
      end
      default: cur = 32'h0000_0000;
    endcase
  end

  // byte lane merge of write data over the current value
  // unselected lanes come back unchanged, so a narrow write cannot disturb them
  for (genvar i = 0; i < 4; i++)
  begin : g_lane
    assign m[i*8 +: 8] = {8{wb_sel_i[i]}};
  end

  assign wv = (cur & ~m) | (wb_dat_i & m);

  // one hot select from the chosen index; 6 and 7 select nothing
  for (genvar i = 0; i < NUM_CS; i++)
  begin : g_sel
    assign cs_dec[i] = (s_q.csel != 3'(i)); // (R6)
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    s_d = s_q;
    s_d.ph = ~s_q.ph; // (R14)
    s_d.ack = req & ~s_q.ack;
    s_d.rdat = (req & ~s_q.ack) ? cur : 32'h0000_0000;
    s_d.warm_req = 1'b0;

    if (wr)
    begin
      unique case (wb_adr_i)
        REG_CTRL:
        begin
          s_d.waits = wv[CTRL_WAIT_LSB +: 4];
          s_d.lanes = wv[CTRL_LANE_LSB +: 2];
          s_d.warm_req = wv[CTRL_WARM_BIT];
        end
        REG_ADDR:
        begin
          s_d.addr = wv[21:0];
          s_d.csel = wv[ADDR_CS_LSB +: 3];
        end
        REG_WDATA: s_d.wdata = wv[15:0];
        REG_CMD:
        begin
          // a start while busy is dropped
          if (wv[CMD_START_BIT] && !busy)
          begin
            s_d.pend = 1'b1;
            s_d.pend_rd = wv[CMD_READ_BIT];
          end
        end
        REG_STATUS:
        begin
          if (wb_sel_i[0] && wb_dat_i[STAT_DONE_BIT])
            s_d.done = 1'b0;
        end
        default:
        begin
        end
      endcase
    end

    // pins move only at a rising bus clock edge
    if (tick) // (R20)
    begin
      if ((warm_active || cold) && s_q.st != ST_IDLE)
      begin
        // reset cuts the cycle; release everything at once
        s_d.st = ST_IDLE;
        s_d.cs_n = 6'h3F;
        s_d.oe_n = 1'b1;
        s_d.we_n = 2'h3;
        s_d.rnw = 1'b1;
        s_d.d_oe = 1'b0;
        s_d.boe_n = 1'b1;
        s_d.dir_n = 1'b1;
      end
      else
      begin
        unique case (s_q.st)
          ST_IDLE:
          begin
            // an alternate master waiting takes precedence over our start
            if (s_q.pend && !granted && bus_ownership_request_n && !warm_active && !cold)
            begin
              s_d.pend = 1'b0;
              s_d.st = ST_SETUP;
              s_d.a_o = s_q.addr; // (R7)
              s_d.cs_n = cs_dec; // (R6)
              s_d.rnw = s_q.pend_rd; // (R2)
              s_d.dir_n = ~s_q.pend_rd; // (R11)
              s_d.boe_n = 1'b0; // (R10)
              s_d.d_o = s_q.wdata;
              s_d.d_oe = ~s_q.pend_rd; // (R8)
            end
          end

          ST_SETUP:
          begin
            // wait count reloads here, so every strobe gets its full length
            s_d.st = ST_STROBE;
            s_d.wcnt = s_q.waits;
            if (s_q.rnw)
              s_d.oe_n = 1'b0; // (R9)
            else
              s_d.we_n = ~s_q.lanes; // (R3)
          end

          ST_STROBE:
          begin
            // read data taken at the last tick, while the far side still drives
            if (s_q.wcnt == 4'h0)
            begin
              if (s_q.rnw)
                s_d.rdata = ext_data_i;
              s_d.oe_n = 1'b1;
              s_d.we_n = 2'h3;
              s_d.st = ST_HOLD;
            end
            else
              s_d.wcnt = s_q.wcnt - 4'h1;
          end

          ST_HOLD:
          begin
            // select outlasts the strobe by one bus clock; address holds until the next start
            s_d.st = ST_IDLE;
            s_d.cs_n = 6'h3F;
            s_d.rnw = 1'b1;
            s_d.d_oe = 1'b0;
            s_d.boe_n = 1'b1;
            s_d.dir_n = 1'b1;
            s_d.done = 1'b1;
          end
        endcase
      end
    end
  end

  // one register stage; pins come from it, from the arbiter and reset control registers, and from the cold reset pin
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      s_q <= MAIN_RST;
    else
      s_q <= s_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // ack and read data both registered, so they stand exactly one cycle
  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = s_q.rdat;
  assign bus_clock_out = s_q.ph; // (R14)
  assign bus_handover_n = ~granted; // (R5) (R1)
  assign bus_drive_en = ~granted; // (R19)

  // data enable also gated by cold reset so the boot vector can be read
  assign ext_data_oe = s_q.d_oe & ~granted & ~cold; // (R8) (R19)
  assign ext_data_o = s_q.d_o;
  assign ext_addr = s_q.a_o;
  assign device_select_n = s_q.cs_n;
  assign read_not_write = s_q.rnw;
  assign read_drive_en_n = s_q.oe_n;
  assign lane_write_strobe_n = s_q.we_n;
  assign buffer_output_en_n = s_q.boe_n;
  assign transceiver_dir_n = s_q.dir_n;
  assign boot_width_16 = boot_vec[BOOT_WIDTH_BIT]; // (R15)
  assign watchdog_en = ~boot_vec[BOOT_WDT_BIT]; // (R17)

endmodule

`default_nettype wire

// [hw/mpbp_pkg.sv]
// constants, state types and reset values of the memory and peripheral bus port
// assumes one clock domain and a synchronous active high reset
`default_nettype none

package mpbp_pkg;

  localparam int unsigned NUM_CS = 6;
  localparam int unsigned ADDR_W = 22;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned WB_AW = 8;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_CMD = 8'h0C;
  localparam logic [7:0] REG_RDATA = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;

  // field positions
  localparam int unsigned CTRL_WAIT_LSB = 0;
  localparam int unsigned CTRL_LANE_LSB = 4;
  localparam int unsigned CTRL_WARM_BIT = 6;
  localparam int unsigned ADDR_CS_LSB = 24;
  localparam int unsigned CMD_START_BIT = 0;
  localparam int unsigned CMD_READ_BIT = 1;
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_DONE_BIT = 1;
  localparam int unsigned STAT_GRANT_BIT = 2;
  localparam int unsigned STAT_WARM_BIT = 3;
  localparam int unsigned STAT_WIDTH_BIT = 4;
  localparam int unsigned STAT_WDT_BIT = 5;
  localparam int unsigned STAT_BOOT_LSB = 16;

  // boot configuration vector bits
  localparam int unsigned BOOT_WIDTH_BIT = 7;
  localparam int unsigned BOOT_RMODE_BIT = 8;
  localparam int unsigned BOOT_WDT_BIT = 12;

  // last count of the warm reset drive, which lasts 4096 sys_clk cycles
  localparam logic [11:0] WARM_LAST = 12'hFFF;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SETUP = 2'b01,
    ST_STROBE = 2'b10,
    ST_HOLD = 2'b11
  } mpbp_state_t;

  typedef struct packed {
    logic ph;
    mpbp_state_t st;
    logic [3:0] wcnt;
    logic pend;
    logic pend_rd;
    logic ack;
    logic [31:0] rdat;
    logic [3:0] waits;
    logic [1:0] lanes;
    logic warm_req;
    logic [21:0] addr;
    logic [2:0] csel;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic done;
    logic [21:0] a_o;
    logic [5:0] cs_n;
    logic rnw;
    logic oe_n;
    logic [1:0] we_n;
    logic [15:0] d_o;
    logic d_oe;
    logic boe_n;
    logic dir_n;
  } mpbp_main_t;

  localparam mpbp_main_t MAIN_RST = '{ph: 1'b0, st: ST_IDLE, wcnt: 4'h0, pend: 1'b0,
    pend_rd: 1'b0, ack: 1'b0, rdat: 32'h0000_0000, waits: 4'h0, lanes: 2'h3,
    warm_req: 1'b0, addr: 22'h00_0000, csel: 3'h0, wdata: 16'h0000, rdata: 16'h0000,
    done: 1'b0, a_o: 22'h00_0000, cs_n: 6'h3F, rnw: 1'b1, oe_n: 1'b1, we_n: 2'h3,
    d_o: 16'h0000, d_oe: 1'b0, boe_n: 1'b1, dir_n: 1'b1};

  typedef struct packed {
    logic [15:0] boot;
    logic [11:0] cnt;
    logic warm;
    logic armed;
  } mpbp_rst_t;

  localparam mpbp_rst_t RSTC_RST = '{boot: 16'h0000, cnt: 12'h000, warm: 1'b0, armed: 1'b0};

  typedef struct packed {
    logic grant;
  } mpbp_arb_t;

  localparam mpbp_arb_t ARB_RST = '{grant: 1'b0};

endpackage

`default_nettype wire

// [hw/mpbp_reset_ctl.sv]
// cold reset boot capture and warm reset pin control
// assumes pins synchronous to sys_clk; reset pin is open drain, pulled up outside
`default_nettype none

module mpbp_reset_ctl
  import mpbp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic power_on_reset_in_n,
  input wire logic soft_reset_in,
  output logic soft_reset_out,
  output logic soft_reset_oe,
  input wire logic sw_warm_req,
  input wire logic [15:0] ext_data_in,
  output logic [15:0] boot_vec,
  output logic warm_active
);

  mpbp_rst_t s_q;
  mpbp_rst_t s_d;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    s_d = s_q;
    if (!power_on_reset_in_n)
    begin
      // vector follows the pins; the last sample before release stays
      s_d.boot = ext_data_in; // (R8) (R12)
      s_d.warm = 1'b1;
      s_d.cnt = 12'h000;
      s_d.armed = 1'b0;
    end
    else if (s_q.warm)
    begin
      // reserved reset mode treated as normal length
      s_d.cnt = s_q.cnt + 12'h001; // (R16)
      if (s_q.cnt == WARM_LAST)
      begin
        s_d.warm = 1'b0;
        s_d.armed = 1'b0;
      end
    end
    else
    begin
      // pin must be seen high once, else our own drive would retrigger
      if (soft_reset_in)
        s_d.armed = 1'b1;
      if (sw_warm_req || (s_q.armed && !soft_reset_in))
      begin
        s_d.warm = 1'b1; // (R13)
        s_d.cnt = 12'h000;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      s_q <= RSTC_RST;
    else
      s_q <= s_d;
  end

  assign soft_reset_out = 1'b0;
  assign soft_reset_oe = s_q.warm; // (R13) (R1)
  assign boot_vec = s_q.boot;
  assign warm_active = s_q.warm;

endmodule

`default_nettype wire

// [hw/mpbp_arbiter.sv]
// bus ownership handover to an alternate master
// assumes bus_idle and tick come from the transaction engine
`default_nettype none

module mpbp_arbiter
  import mpbp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic bus_ownership_request_n,
  input wire logic bus_idle,
  input wire logic tick,
  output logic granted
);

  mpbp_arb_t s_q;
  mpbp_arb_t s_d;

  always_comb
  begin
    s_d = s_q;
    if (tick)
    begin
      // handover only between transactions, so no cycle is cut short
      if (!s_q.grant && !bus_ownership_request_n && bus_idle)
        s_d.grant = 1'b1; // (R4) (R5)
      else if (s_q.grant && bus_ownership_request_n)
        s_d.grant = 1'b0; // (R19)
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      s_q <= ARB_RST;
    else
      s_q <= s_d;
  end

  assign granted = s_q.grant;

endmodule

`default_nettype wire

// [tb/mpbp_ext_model.sv]
// far side of the port: 16-word memory and boot vector source
// assumes the bench holds the cold reset pin and the vector to present
`default_nettype none

module mpbp_ext_model
(
  input wire logic sys_clk,
  input wire logic power_on_reset_in_n,
  input wire logic [15:0] boot_vec,
  input wire logic [5:0] device_select_n,
  input wire logic [21:0] ext_addr,
  input wire logic [1:0] lane_write_strobe_n,
  input wire logic read_drive_en_n,
  input wire logic [15:0] ext_data_o,
  input wire logic ext_data_oe,
  output logic [15:0] ext_data_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [16];
  logic [15:0] last = 16'h0000;
  logic hit;
  ////////////////////////////////////////////////////////////
  assign hit = device_select_n != 6'h3F;
  // no pull on the data pins: a released bus toggles
  always_comb
  begin
    if (ext_data_oe)
      ext_data_i = ext_data_o;
    else if (!power_on_reset_in_n)
      ext_data_i = boot_vec;
    else if (hit && !read_drive_en_n)
      ext_data_i = mem[ext_addr[3:0]];
    else
      ext_data_i = ~last;
  end
  always_ff @(posedge sys_clk)
  begin
    last <= ext_data_i;
    if (hit && !lane_write_strobe_n[0])
      mem[ext_addr[3:0]][7:0] <= ext_data_o[7:0];
    if (hit && !lane_write_strobe_n[1])
      mem[ext_addr[3:0]][15:8] <= ext_data_o[15:8];
  end
endmodule

`default_nettype wire

// [tb/mpbp_checker.sv]
// pin relations of the bus port
// assumes binding to mpbp_port, one clock domain
`default_nettype none

module mpbp_checker
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic bus_clock_out,
  input wire logic soft_reset_io_n_oe,
  input wire logic transceiver_dir_n,
  input wire logic bus_ownership_request_n,
  input wire logic bus_handover_n,
  input wire logic bus_drive_en,
  input wire logic [1:0] lane_write_strobe_n,
  input wire logic [5:0] device_select_n,
  input wire logic [21:0] ext_addr,
  input wire logic ext_data_oe,
  input wire logic read_drive_en_n,
  input wire logic read_not_write
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [15:0] warm_q;
  ////////////////////////////////////////////////////////////
  // run length of the warm drive, saturating
  always_ff @(posedge sys_clk)
  begin
    if (rst || !soft_reset_io_n_oe)
      warm_q <= 16'h0000;
    else if (warm_q != 16'hFFFF)
      warm_q <= warm_q + 16'h0001;
  end
  // phase settles two edges after reset
  sequence s_run;
    !rst ##1 !rst ##1 !rst;
  endsequence
  sequence s_pins_move;
    $changed(device_select_n) || $changed(ext_addr) || $changed(read_not_write);
  endsequence
  property p_clk;
    s_run |-> bus_clock_out != $past(bus_clock_out);
  endproperty
  property p_edge;
    s_pins_move |-> $rose(bus_clock_out);
  endproperty
  property p_read;
    !read_drive_en_n |-> read_not_write && lane_write_strobe_n == 2'h3 && !ext_data_oe;
  endproperty
  property p_write;
    lane_write_strobe_n != 2'h3 |-> !read_not_write && ext_data_oe && read_drive_en_n;
  endproperty
  property p_float;
    !bus_handover_n |-> !bus_drive_en && !ext_data_oe;
  endproperty
  property p_grant;
    $fell(bus_handover_n) |-> !$past(bus_ownership_request_n);
  endproperty
  property p_dir;
    ext_data_oe |-> transceiver_dir_n;
  endproperty
  property p_sel;
    $countones(~device_select_n) <= 1;
  endproperty
  property p_warm;
    $fell(soft_reset_io_n_oe) |-> warm_q >= 16'h1000;
  endproperty
  a_clk: assert property (p_clk) else $error("bus clock did not toggle");
  a_edge: assert property (p_edge) else $error("pins moved off bus clock rise");
  a_read: assert property (p_read) else $error("read enable outside a read");
  a_write: assert property (p_write) else $error("lane strobe outside a write");
  a_float: assert property (p_float) else $error("pins driven while granted");
  a_grant: assert property (p_grant) else $error("grant without request");
  a_dir: assert property (p_dir) else $error("transceiver inbound while driving");
  a_sel: assert property (p_sel) else $error("more than one select");
  a_warm: assert property (p_warm) else $error("warm drive too short");
endmodule

bind mpbp_port mpbp_checker u_chk (.sys_clk, .rst, .bus_clock_out, .soft_reset_io_n_oe,
  .transceiver_dir_n, .bus_ownership_request_n, .bus_handover_n, .bus_drive_en,
  .lane_write_strobe_n, .device_select_n, .ext_addr, .ext_data_oe, .read_drive_en_n,
  .read_not_write);

`default_nettype wire

// [tb/testbench.sv]
// bench: wishbone register traffic, bus transactions, boot and warm reset
// assumes mpbp_ext_model on the pins, bench as alternate master
`default_nettype none

module testbench
  import mpbp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, q;
  logic [3:0] wb_sel_i = 4'hF;
  logic power_on_reset_in_n = 1'b1, bus_ownership_request_n = 1'b1, pull = 1'b0;
  logic [15:0] boot_vec = 16'h0000, ext_data_i, ext_data_o;
  logic wb_ack_o, bus_clock_out, soft_reset_io_n_i, soft_reset_io_n_o, soft_reset_io_n_oe;
  logic transceiver_dir_n, buffer_output_en_n, bus_handover_n, bus_drive_en, ext_data_oe;
  logic read_drive_en_n, read_not_write, boot_width_16, watchdog_en;
  logic [1:0] lane_write_strobe_n;
  logic [5:0] device_select_n;
  logic [21:0] ext_addr;
  int failures = 0, checks = 0, cyc_n = 0;
  ////////////////////////////////////////////////////////////
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc_n <= cyc_n + 1;
  // open drain pin with pull-up
  assign soft_reset_io_n_i = !((soft_reset_io_n_oe && !soft_reset_io_n_o) || pull);
  mpbp_port DUT (.*);
  mpbp_ext_model u_mem (.*);

  task automatic complete_run();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      $display("Error %s expected %h seen %h", n, e, g);
      failures++;
    end
  endtask

  task automatic await(ref logic s, input logic v, input int lim);
    int n;
    n = 0;
    while (s !== v && n < lim)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk("wait bound", 32'(v), 32'(s));
    if (s !== v)
      complete_run();
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge sys_clk);
    await(wb_ack_o, 1'b1, 20);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    wb(1'b0, a, 32'h0000_0000, r);
  endtask

  task automatic xact(input logic [2:0] cs, input logic [21:0] a, input logic rw, input logic [1:0] ln,
    input logic [15:0] d);
    logic [31:0] r;
    logic [5:0] s;
    int n;
    s = ~(6'h01 << cs);
    wr(REG_CTRL, 32'(ln) << CTRL_LANE_LSB | 32'h1);
    wr(REG_ADDR, 32'(cs) << ADDR_CS_LSB | 32'(a));
    wr(REG_WDATA, 32'(d));
    wr(REG_CMD, {30'h0, rw, 1'b1});
    n = 0;
    while (device_select_n === 6'h3F && n < 40)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk("select", 32'(s), 32'(device_select_n));
    chk("address", 32'(a), 32'(ext_addr));
    chk("direction", 32'(rw), 32'(read_not_write));
    chk("buffer enable", 32'h0, 32'(buffer_output_en_n));
    chk("transceiver", 32'(!rw), 32'(transceiver_dir_n));
    if (device_select_n === 6'h3F)
      complete_run();
    n = 0;
    do
    begin
      rd(REG_STATUS, r);
      n++;
    end
    while (r[STAT_DONE_BIT] !== 1'b1 && n < 30);
    chk("done", 32'h1, 32'(r[STAT_DONE_BIT]));
    if (r[STAT_DONE_BIT] !== 1'b1)
      complete_run();
    wr(REG_STATUS, 32'h0000_0002);
  endtask

  task automatic lane(input logic [2:0] cs, input logic [21:0] a, input logic [1:0] ln,
    input logic [15:0] d, input logic [15:0] e);
    logic [31:0] r;
    xact(cs, a, 1'b0, ln, d);
    xact(cs, a, 1'b1, 2'h3, 16'h0000);
    rd(REG_RDATA, r);
    chk("read data", 32'(e), r);
  endtask

  task automatic warm_len(input logic cold);
    logic [31:0] r;
    int t;
    await(soft_reset_io_n_oe, 1'b1, 20);
    t = cyc_n;
    if (cold)
      power_on_reset_in_n <= 1'b1;
    rd(REG_STATUS, r);
    chk("warm flag", 32'h1, 32'(r[STAT_WARM_BIT]));
    chk("warm level", 32'h0, 32'(soft_reset_io_n_o));
    await(soft_reset_io_n_oe, 1'b0, 6000);
    chk("warm length", 32'h1, 32'(cyc_n - t >= 4096));
  endtask

  task automatic boot(input logic [15:0] v);
    logic [31:0] r;
    boot_vec <= v;
    power_on_reset_in_n <= 1'b0;
    repeat (20) @(posedge sys_clk);
    warm_len(1'b1);
    rd(REG_STATUS, r);
    chk("boot vector", 32'(v), r >> STAT_BOOT_LSB);
    chk("width", 32'(v[BOOT_WIDTH_BIT]), 32'(boot_width_16));
    chk("watchdog", 32'(!v[BOOT_WDT_BIT]), 32'(watchdog_en));
  endtask

  task automatic handover();
    bus_ownership_request_n <= 1'b0;
    await(bus_handover_n, 1'b0, 40);
    chk("drive", 32'h0, 32'(bus_drive_en));
    chk("data drive", 32'h0, 32'(ext_data_oe));
    bus_ownership_request_n <= 1'b1;
    await(bus_handover_n, 1'b1, 40);
  endtask

  initial
  begin
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    boot(16'h1080);
    boot(16'h0000);
    lane(3'h2, 22'h2A5C5, 2'h3, 16'hA5C3, 16'hA5C3);
    lane(3'h0, 22'h3FFFF5, 2'h1, 16'h1234, 16'hA534);
    lane(3'h5, 22'h000005, 2'h2, 16'h7F00, 16'h7F34);
    wr(REG_RDATA, 32'h0000_FFFF);
    wr(8'h18, 32'hFFFF_FFFF);
    rd(REG_RDATA, q);
    chk("rdata kept", 32'h0000_7F34, q);
    rd(8'h18, q);
    chk("unmapped", 32'h0000_0000, q);
    handover();
    wr(REG_CTRL, 32'h0000_0070);
    warm_len(1'b0);
    repeat (2) @(posedge sys_clk);
    pull <= 1'b1;
    // one cycle of outside pull, so the length is timed from our own drive
    @(posedge sys_clk);
    pull <= 1'b0;
    warm_len(1'b0);
    complete_run();
  end
endmodule

`default_nettype wire
